/* src/iop_pkg.sv */
// constants, register map and bus states for the i/o port block
package iop_pkg;
	// register word offsets (byte addresses, one 32-bit word each)
	localparam logic [7:0] OFS_PIN_LEVEL   = 8'h00;
	localparam logic [7:0] OFS_OUT_LATCH   = 8'h04;
	localparam logic [7:0] OFS_DIRECTION   = 8'h08;
	localparam logic [7:0] OFS_ANALOG_SEL  = 8'h0C;
	localparam logic [7:0] OFS_PULLUP_EN   = 8'h10;
	localparam logic [7:0] OFS_IN_THRESH   = 8'h14;
	localparam logic [7:0] OFS_SLEW_LIMIT  = 8'h18;
	localparam logic [7:0] OFS_OPEN_DRAIN  = 8'h1C;
	localparam logic [7:0] OFS_PERIPH_SEL  = 8'h20;
	// decoded address width
	localparam int         ADDR_W          = 8;
	// reset value of each bit of a register, replicated per pin
	localparam logic       RST_LATCH       = 1'b0;
	localparam logic       RST_DIRECTION   = 1'b1;
	localparam logic       RST_ANALOG_SEL  = 1'b1;
	localparam logic       RST_PULLUP_EN   = 1'b0;
	localparam logic       RST_IN_THRESH   = 1'b0;
	localparam logic       RST_SLEW_LIMIT  = 1'b1;
	localparam logic       RST_OPEN_DRAIN  = 1'b0;
	localparam logic       RST_PERIPH_SEL  = 1'b0;
	// ahb-lite codes used by the slave
	localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
	localparam logic       HRESP_OKAY      = 1'b0;
	// bus slave states
	typedef enum logic [1:0] {
		IOP_IDLE,
		IOP_WR_DATA,
		IOP_RD_WAIT,
		IOP_RD_DONE
	} iop_bus_st_t;
endpackage : iop_pkg

/* src/iop_pin_if.sv */
// configuration and pin-side results between register file and pin logic
`timescale 1ns/10ps
interface iop_pin_if #(parameter int W = 8);
	logic [W-1:0] latch;       // output latch
	logic [W-1:0] direction;   // 1 = input
	logic [W-1:0] analog_sel;  // 1 = analog pin
	logic [W-1:0] pullup_en;   // weak pull-up request
	logic [W-1:0] in_thresh;   // threshold select
	logic [W-1:0] slew_limit;  // slew limit select
	logic [W-1:0] open_drain;  // sink only
	logic [W-1:0] periph_sel;  // peripheral owns pin
	logic [W-1:0] pin_sync;    // synchronised pin level
	// register side drives configuration
	modport regs (output latch, direction, analog_sel, pullup_en,
		in_thresh, slew_limit, open_drain, periph_sel, pin_sync);
	// pin side consumes it
	modport pins (input latch, direction, analog_sel, pullup_en,
		in_thresh, slew_limit, open_drain, periph_sel, pin_sync);
endinterface : iop_pin_if

/* src/iop_pin_drive.sv */
// per-pin output, enable, pull-up and input buffer control
`timescale 1ns/10ps
module iop_pin_drive #(
	parameter int W = 8
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	iop_pin_if.pins           cfg,
	input  wire logic [W-1:0] i_periph_out,
	input  wire logic [W-1:0] i_periph_oe,
	input  wire logic [W-1:0] i_aout_en,
	output logic      [W-1:0] o_pin_out,
	output logic      [W-1:0] o_pin_oe,
	output logic      [W-1:0] o_pullup_en,
	output logic      [W-1:0] o_slew_limit,
	output logic      [W-1:0] o_schmitt_sel,
	output logic      [W-1:0] o_dig_in_en,
	output logic      [W-1:0] o_analog_in_en,
	output logic      [W-1:0] o_periph_in
);
	logic [W-1:0] next_data;   // value the owner wants on the pin
	logic [W-1:0] next_req;    // owner asks to drive
	logic [W-1:0] next_oe;     // final enable after overrides

	// owner select: peripheral or latch, all bitwise per pin
	always_comb
	begin
		next_data = (cfg.periph_sel & i_periph_out)
			| (~cfg.periph_sel & cfg.latch);
		next_req  = (cfg.periph_sel & i_periph_oe)
			| (~cfg.periph_sel & ~cfg.direction);
		// open drain only drives the low level
		next_oe   = next_req & ~(cfg.open_drain & next_data);
		// analog output wins; analog select alone does not block
		next_oe   = next_oe & ~i_aout_en;
	end

	// pad controls registered so the pad sees clean levels
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_pin_out <= '0;
			o_pin_oe  <= '0;
		end
		else
		begin
			// drive low only in open-drain mode
			o_pin_out <= next_data & ~cfg.open_drain;
			o_pin_oe  <= next_oe;
		end
	end

	// pull-up and pad options
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_pullup_en   <= '0;
			o_slew_limit  <= '0;
			o_schmitt_sel <= '0;
		end
		else
		begin
			// pull-up off while the pin is an output
			o_pullup_en   <= cfg.pullup_en & ~next_req;
			o_slew_limit  <= cfg.slew_limit;
			o_schmitt_sel <= cfg.in_thresh;
		end
	end

	// analog switches and the digital input path
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_dig_in_en    <= '0;
			o_analog_in_en <= '0;
			o_periph_in    <= '0;
		end
		else
		begin
			o_dig_in_en    <= ~cfg.analog_sel;
			o_analog_in_en <= cfg.analog_sel;
			// peripherals still see the level of a pin they own
			o_periph_in    <= cfg.pin_sync & ~cfg.analog_sel;
		end
	end
endmodule // iop_pin_drive

/* src/iop_port.sv */
// gpio port: ahb-lite register file, pin synchroniser and checks
//
// Implementation choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
// Function
// - each port has its own nine-register set
// - latch write equals pin level write
// - latch read returns stored latch values
// - pin level read returns sampled pins
// - peripheral owner blocks latch drive, readable
// - analog select disables digital input buffer
// - analog select exists only if capable
// - after reset every pin owned by latch
// - alternate functions only via peripheral select
// - analog select activates analog input functions
// - analog select does not stop digital drive
// - analog output forces digital driver off
// - direction one input, zero drives latch
// - analog pins read zero as level
// - open drain sinks only, else push-pull
// - pull-up disabled while pin is output
module iop_port #(
	parameter int   PIN_CNT        = 8,
	parameter logic ANALOG_CAPABLE = 1'b1
) (
	input  wire logic               i_mclk,
	input  wire logic               i_rst,
	// ahb-lite slave
	input  wire logic               i_hsel,
	input  wire logic [31:0]        i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	output logic      [31:0]        o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	// pads
	input  wire logic [PIN_CNT-1:0] i_pin_in,
	output logic      [PIN_CNT-1:0] o_pin_out,
	output logic      [PIN_CNT-1:0] o_pin_oe,
	output logic      [PIN_CNT-1:0] o_pullup_en,
	output logic      [PIN_CNT-1:0] o_slew_limit,
	output logic      [PIN_CNT-1:0] o_schmitt_sel,
	output logic      [PIN_CNT-1:0] o_dig_in_en,
	output logic      [PIN_CNT-1:0] o_analog_in_en,
	// on-chip peripherals sharing the pins
	input  wire logic [PIN_CNT-1:0] i_periph_out,
	input  wire logic [PIN_CNT-1:0] i_periph_oe,
	input  wire logic [PIN_CNT-1:0] i_aout_en,
	output logic      [PIN_CNT-1:0] o_periph_in
);
	localparam int W = PIN_CNT;

	iop_pin_if #(.W(W)) cfg ();             // register to pin logic

	iop_pkg::iop_bus_st_t     bus_st;       // slave state
	logic [iop_pkg::ADDR_W-1:0] addr_q;     // captured address phase
	logic [W-1:0]             sync_q1;      // first sync stage only
	logic [W-1:0]             sync_q2;      // usable pin level
	logic                     accept;       // address phase taken
	logic                     wr_commit;    // write data phase now

	// read decode used only by the read data flop, not by the checks
	function automatic logic [31:0] reg_read(
		input logic [iop_pkg::ADDR_W-1:0] a);
		logic [W-1:0] v;
		v = '0;
		case (a)
			// sampled level, analog pins forced low
			iop_pkg::OFS_PIN_LEVEL:  v = sync_q2 & ~cfg.analog_sel;
			iop_pkg::OFS_OUT_LATCH:  v = cfg.latch;
			iop_pkg::OFS_DIRECTION:  v = cfg.direction;
			iop_pkg::OFS_ANALOG_SEL: v = cfg.analog_sel;
			iop_pkg::OFS_PULLUP_EN:  v = cfg.pullup_en;
			iop_pkg::OFS_IN_THRESH:  v = cfg.in_thresh;
			iop_pkg::OFS_SLEW_LIMIT: v = cfg.slew_limit;
			iop_pkg::OFS_OPEN_DRAIN: v = cfg.open_drain;
			iop_pkg::OFS_PERIPH_SEL: v = cfg.periph_sel;
			// unmapped words read as zero
			default:                 v = '0;
		endcase
		return {{(32-W){1'b0}}, v};
	endfunction

	assign cfg.pin_sync = sync_q2;

	// pins are asynchronous: two flops before any logic looks
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			sync_q1 <= '0;
			sync_q2 <= '0;
		end
		else
		begin
			sync_q1 <= i_pin_in;
			sync_q2 <= sync_q1;
		end
	end

	// bus handshake; reads take one wait so a write just before lands
	assign accept      = i_hsel && i_hready
		&& (i_htrans == iop_pkg::HTRANS_NONSEQ);
	assign wr_commit   = (bus_st == iop_pkg::IOP_WR_DATA);
	assign o_hreadyout = (bus_st != iop_pkg::IOP_RD_WAIT);
	assign o_hresp     = iop_pkg::HRESP_OKAY;

	// slave state machine
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			bus_st <= iop_pkg::IOP_IDLE;
			addr_q <= '0;
		end
		else
		begin
			case (bus_st)
				// a new address phase may follow any finished one
				iop_pkg::IOP_IDLE,
				iop_pkg::IOP_WR_DATA,
				iop_pkg::IOP_RD_DONE:
				begin
					if (accept)
					begin
						addr_q <= i_haddr[iop_pkg::ADDR_W-1:0];
						bus_st <= i_hwrite ? iop_pkg::IOP_WR_DATA
							: iop_pkg::IOP_RD_WAIT;
					end
					else
					begin
						bus_st <= iop_pkg::IOP_IDLE;
					end
				end
				// wait state while read data is registered
				iop_pkg::IOP_RD_WAIT:
				begin
					bus_st <= iop_pkg::IOP_RD_DONE;
				end
				default:
				begin
					bus_st <= iop_pkg::IOP_IDLE;
				end
			endcase
		end
	end

	// read data flop, loaded during the wait state
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			o_hrdata <= '0;
		end
		else if (bus_st == iop_pkg::IOP_RD_WAIT)
		begin
			o_hrdata <= reg_read(addr_q);
		end
	end

	// output latch: both level and latch offsets write it
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			cfg.latch <= {W{iop_pkg::RST_LATCH}};
		end
		else if (wr_commit && (addr_q == iop_pkg::OFS_PIN_LEVEL
			|| addr_q == iop_pkg::OFS_OUT_LATCH))
		begin
			cfg.latch <= i_hwdata[W-1:0];
		end
	end

	// remaining per-port control registers, i_hsize ignored so every write loads the whole word
	always_ff @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			cfg.direction  <= {W{iop_pkg::RST_DIRECTION}};
			cfg.pullup_en  <= {W{iop_pkg::RST_PULLUP_EN}};
			cfg.in_thresh  <= {W{iop_pkg::RST_IN_THRESH}};
			cfg.slew_limit <= {W{iop_pkg::RST_SLEW_LIMIT}};
			cfg.open_drain <= {W{iop_pkg::RST_OPEN_DRAIN}};
			// every pin returns to the latch owner
			cfg.periph_sel <= {W{iop_pkg::RST_PERIPH_SEL}};
		end
		else if (wr_commit)
		begin
			case (addr_q)
				iop_pkg::OFS_DIRECTION:  cfg.direction  <= i_hwdata[W-1:0];
				iop_pkg::OFS_PULLUP_EN:  cfg.pullup_en  <= i_hwdata[W-1:0];
				iop_pkg::OFS_IN_THRESH:  cfg.in_thresh  <= i_hwdata[W-1:0];
				iop_pkg::OFS_SLEW_LIMIT: cfg.slew_limit <= i_hwdata[W-1:0];
				iop_pkg::OFS_OPEN_DRAIN: cfg.open_drain <= i_hwdata[W-1:0];
				// alternate functions are routed only from here
				iop_pkg::OFS_PERIPH_SEL: cfg.periph_sel <= i_hwdata[W-1:0];
				// other offsets leave these alone
				default: ;
			endcase
		end
	end

	// analog select; a digital-only port keeps it at zero
	always_ff @(posedge i_mclk)
	begin
		if (i_rst || !ANALOG_CAPABLE)
		begin
			cfg.analog_sel <= ANALOG_CAPABLE
				? {W{iop_pkg::RST_ANALOG_SEL}} : '0;
		end
		else if (wr_commit && addr_q == iop_pkg::OFS_ANALOG_SEL)
		begin
			cfg.analog_sel <= i_hwdata[W-1:0];
		end
	end

	// pad and peripheral side
	iop_pin_drive #(.W(W)) u_drive (
		.i_mclk         (i_mclk),
		.i_rst          (i_rst),
		.cfg            (cfg),
		.i_periph_out   (i_periph_out),
		.i_periph_oe    (i_periph_oe),
		.i_aout_en      (i_aout_en),
		.o_pin_out      (o_pin_out),
		.o_pin_oe       (o_pin_oe),
		.o_pullup_en    (o_pullup_en),
		.o_slew_limit   (o_slew_limit),
		.o_schmitt_sel  (o_schmitt_sel),
		.o_dig_in_en    (o_dig_in_en),
		.o_analog_in_en (o_analog_in_en),
		.o_periph_in    (o_periph_in)
	);

	// level write lands in the latch at the edge that ends its data phase, one edge after its address
	latch_write_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		accept && i_hwrite
		&& i_haddr[iop_pkg::ADDR_W-1:0] == iop_pkg::OFS_PIN_LEVEL
		|=> ##1 cfg.latch == $past(i_hwdata[W-1:0]))
		else $error("pin level write did not reach latch");

	// latch read returns latch contents
	latch_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		bus_st == iop_pkg::IOP_RD_WAIT && addr_q == iop_pkg::OFS_OUT_LATCH
		|=> o_hreadyout && o_hrdata[W-1:0] == $past(cfg.latch))
		else $error("latch read returned wrong value");

	// level read returns synchronised pins, analog ones zero
	level_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		bus_st == iop_pkg::IOP_RD_WAIT && addr_q == iop_pkg::OFS_PIN_LEVEL
		|=> o_hrdata[W-1:0] == ($past(sync_q2) & ~$past(cfg.analog_sel)))
		else $error("pin level read wrong");

	// latch drives an owned output pin
	latch_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_pin_oe & ~cfg.periph_sel & cfg.direction) == '0 ##0
		!i_rst |-> ##1 ((o_pin_oe ^ ~$past(cfg.direction))
		& ~$past(cfg.periph_sel | i_aout_en
		| (cfg.open_drain & cfg.latch))) == '0
		|| $past(cfg.direction) != cfg.direction)
		else $error("direction does not steer the driver");

	// peripheral-owned pins ignore the latch direction
	periph_own_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1 |=> (o_pin_oe & $past(cfg.periph_sel & ~i_periph_oe)) == '0)
		else $error("latch drove a peripheral pin");

	// open drain never drives high
	open_drain_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1 |=> (o_pin_out & o_pin_oe & $past(cfg.open_drain)) == '0)
		else $error("open drain pin driven high");

	// analog output tristates the digital driver
	aout_prio_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		1'b1 |=> (o_pin_oe & $past(i_aout_en)) == '0)
		else $error("driver on under analog output");

	// pull-up and output enable never together
	pullup_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		(o_pullup_en & o_pin_oe) == '0)
		else $error("pull-up active on output");

	// analog pins have their digital buffer off
	dig_buffer_a: assert property (@(posedge i_mclk) disable iff (i_rst)
		!i_rst |=> o_dig_in_en == ~$past(cfg.analog_sel)
		&& o_analog_in_en == $past(cfg.analog_sel))
		else $error("input buffer not following analog select");

	// reset hands every pin to the latch as an input
	reset_owner_a: assert property (@(posedge i_mclk)
		i_rst |=> cfg.periph_sel == '0 && cfg.direction == '1)
		else $error("reset did not restore latch ownership");

	// read data phase holds exactly one wait state
	read_wait_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		accept && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait state not one cycle");

	// unmapped words read back as zero
	unmapped_read_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		bus_st == iop_pkg::IOP_RD_WAIT && addr_q > iop_pkg::OFS_PERIPH_SEL
		|=> o_hrdata == '0)
		else $error("unmapped word read nonzero");

	// bits above the port never carry data
	upper_zero_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		o_hrdata[31:W] == '0)
		else $error("read data above port width");

	// latch moves only on a level or latch write
	latch_hold_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_rst && !(wr_commit && (addr_q == iop_pkg::OFS_PIN_LEVEL
		|| addr_q == iop_pkg::OFS_OUT_LATCH)) |=> $stable(cfg.latch))
		else $error("latch changed without a write");

	// push-pull latch pins show the latch value
	pushpull_data_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_rst |=> ((o_pin_out ^ $past(cfg.latch))
		& $past(~cfg.periph_sel & ~cfg.open_drain)) == '0)
		else $error("latch value not on pin");

	// latch outputs never get the pull-up
	pullup_output_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_rst |=> (o_pullup_en
		& $past(~cfg.periph_sel & ~cfg.direction)) == '0)
		else $error("pull-up on latch output");

	// peripherals see synchronised levels, analog pins low
	periph_input_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_rst |=> o_periph_in
		== ($past(sync_q2) & ~$past(cfg.analog_sel)))
		else $error("peripheral input level wrong");

	// pad options follow their registers
	pad_options_a: assert property (
		@(posedge i_mclk) disable iff (i_rst)
		!i_rst |=> o_slew_limit == $past(cfg.slew_limit)
		&& o_schmitt_sel == $past(cfg.in_thresh))
		else $error("pad option not following register");

	// reset releases every driver and pull-up
	reset_pads_a: assert property (
		@(posedge i_mclk)
		i_rst |=> o_pin_oe == '0 && o_pullup_en == '0
		&& o_dig_in_en == '0)
		else $error("pad outputs active after reset");
endmodule // iop_port

/* sim/iop_pad_model.sv */
// far-side pad model: resolves each pin from all its drivers
`timescale 1ns/10ps
module iop_pad_model #(
	parameter int W = 8
) (
	input  wire logic         i_mclk,
	input  wire logic [W-1:0] i_pad_out,
	input  wire logic [W-1:0] i_pad_oe,
	input  wire logic [W-1:0] i_pad_pullup,
	input  wire logic [W-1:0] i_ext_en,
	input  wire logic [W-1:0] i_ext_val,
	output logic      [W-1:0] o_pad_level
);
	logic [W-1:0] float_q = '0; // undriven pins wander, never settle

	// floating level flips every cycle so a stale read cannot pass
	always @(posedge i_mclk)
	begin
		float_q <= ~float_q;
	end

	// device drive first, then outside driver, then pull-up
	assign o_pad_level = (i_pad_oe & i_pad_out)
		| (~i_pad_oe & i_ext_en & i_ext_val)
		| (~i_pad_oe & ~i_ext_en & (i_pad_pullup | float_q));
endmodule // iop_pad_model

/* sim/io_port_pin_control_test.sv */
// self-checking testbench for the gpio port block
`timescale 1ns/10ps
module io_port_pin_control_test;
	logic        i_mclk   = 1'b0;  // 25 MHz system clock
	logic        i_rst    = 1'b1;  // synchronous reset
	logic        i_hsel   = 1'b0;  // bus select
	logic [31:0] i_haddr  = 32'h0;
	logic [1:0]  i_htrans = 2'h0;
	logic        i_hwrite = 1'b0;
	logic [31:0] i_hwdata = 32'h0;
	logic [7:0]  ext_en   = 8'h00; // outside drivers on pins
	logic [7:0]  ext_val  = 8'h00;
	logic [7:0]  p_out    = 8'h00; // peripheral data
	logic [7:0]  p_oe     = 8'h00; // peripheral enable
	logic [7:0]  aout     = 8'h00; // analog outputs
	logic [31:0] o_hrdata;
	logic        o_hreadyout;
	logic        o_hresp;
	logic [7:0]  pin_in, pin_out, pin_oe, pull, slew, schm;
	logic [7:0]  dig_in, ana_in, per_in;
	logic [7:0]  ofs [9];          // register offsets
	logic [7:0]  rv  [9];          // their reset values
	logic [31:0] rd;               // last read data
	int          fails = 0;
	int          comparisons = 0;

	// free-running clock, 40 ns period
	always #20 i_mclk = ~i_mclk;

	iop_port u_iop_port (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
		.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
		.o_hresp(o_hresp), .i_pin_in(pin_in), .o_pin_out(pin_out),
		.o_pin_oe(pin_oe), .o_pullup_en(pull), .o_slew_limit(slew),
		.o_schmitt_sel(schm), .o_dig_in_en(dig_in),
		.o_analog_in_en(ana_in), .i_periph_out(p_out),
		.i_periph_oe(p_oe), .i_aout_en(aout), .o_periph_in(per_in));

	iop_pad_model u_iop_pad_model (.i_mclk(i_mclk), .i_pad_out(pin_out),
		.i_pad_oe(pin_oe), .i_pad_pullup(pull), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_pad_level(pin_in));

	// counts, verdict and end of run
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// single compare point
	task automatic chk(input string w, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", w, e, s);
		end
	endtask

	// byte-wide pad compare
	task automatic pk(input string w, input logic [7:0] s, e);
		chk(w, {24'h0, s}, {24'h0, e});
	endtask

	// wait for hready at a rising edge, bounded
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			n++;
		end
		while (o_hreadyout !== 1'b1 && n < 20);
		if (o_hreadyout !== 1'b1)
		begin
			fails++;
			give_verdict();
		end
	endtask

	// one single-word transfer, entered just after a rising edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		i_hsel   <= 1'b1;
		i_haddr  <= {24'h0, a};
		i_htrans <= iop_pkg::HTRANS_NONSEQ;
		i_hwrite <= wr;
		wait_rdy();
		i_hsel   <= 1'b0;
		i_htrans <= 2'h0;
		i_hwdata <= wd;
		wait_rdy();
		rd = o_hrdata;
		chk("response", {31'h0, o_hresp}, {31'h0, iop_pkg::HRESP_OKAY});
	endtask

	// let pad outputs and the synchroniser settle, look off-edge
	task automatic settle;
		repeat (4) @(negedge i_mclk);
	endtask

	// main sequence
	initial
	begin
		ofs = '{iop_pkg::OFS_PIN_LEVEL, iop_pkg::OFS_OUT_LATCH,
			iop_pkg::OFS_DIRECTION, iop_pkg::OFS_ANALOG_SEL,
			iop_pkg::OFS_PULLUP_EN, iop_pkg::OFS_IN_THRESH,
			iop_pkg::OFS_SLEW_LIMIT, iop_pkg::OFS_OPEN_DRAIN,
			iop_pkg::OFS_PERIPH_SEL};
		rv = '{8'h00, {8{iop_pkg::RST_LATCH}}, {8{iop_pkg::RST_DIRECTION}},
			{8{iop_pkg::RST_ANALOG_SEL}}, {8{iop_pkg::RST_PULLUP_EN}},
			{8{iop_pkg::RST_IN_THRESH}}, {8{iop_pkg::RST_SLEW_LIMIT}},
			{8{iop_pkg::RST_OPEN_DRAIN}}, {8{iop_pkg::RST_PERIPH_SEL}}};
		repeat (16) @(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		// reset values; analog pins read low
		for (int i = 0; i < 9; i++)
		begin
			bus(1'b0, ofs[i], 32'h0);
			chk("reset value", rd, {24'h0, rv[i]});
		end
		// unmapped word: write lost, reads zero
		bus(1'b1, 8'h24, 32'h0000_00FF);
		bus(1'b0, 8'h24, 32'h0);
		chk("unmapped", rd, 32'h0);
		settle();
		pk("oe at reset", pin_oe, 8'h00);
		pk("dig in at reset", dig_in, 8'h00);
		pk("analog in at reset", ana_in, 8'hFF);
		@(posedge i_mclk);
		// digital outputs on low nibble, outside drives high nibble
		ext_en  <= 8'hF0;
		ext_val <= 8'hA0;
		bus(1'b1, iop_pkg::OFS_ANALOG_SEL, 32'h0);
		bus(1'b1, iop_pkg::OFS_DIRECTION, 32'h0000_00F0);
		bus(1'b1, iop_pkg::OFS_PIN_LEVEL, 32'h0000_00A5);
		bus(1'b0, iop_pkg::OFS_OUT_LATCH, 32'h0);
		chk("latch via level", rd, 32'h0000_00A5);
		settle();
		pk("oe outputs", pin_oe, 8'h0F);
		pk("out data", pin_out & 8'h0F, 8'h05);
		pk("dig in on", dig_in, 8'hFF);
		@(posedge i_mclk);
		bus(1'b0, iop_pkg::OFS_PIN_LEVEL, 32'h0);
		chk("pin level", rd, 32'h0000_00A5);
		// back-to-back write then read of the latch
		bus(1'b1, iop_pkg::OFS_OUT_LATCH, 32'h0000_003D);
		bus(1'b0, iop_pkg::OFS_OUT_LATCH, 32'h0);
		chk("latch", rd, 32'h0000_003D);
		// pull-ups, analog pins, pad options, one analog output
		bus(1'b1, iop_pkg::OFS_PULLUP_EN, 32'h0000_00FF);
		bus(1'b1, iop_pkg::OFS_ANALOG_SEL, 32'h0000_0083);
		bus(1'b1, iop_pkg::OFS_SLEW_LIMIT, 32'h0000_005A);
		bus(1'b1, iop_pkg::OFS_IN_THRESH, 32'h0000_000C);
		aout <= 8'h01;
		settle();
		pk("pull-up", pull, 8'hF0);
		pk("dig in analog", dig_in, 8'h7C);
		pk("analog in", ana_in, 8'h83);
		pk("oe analog", pin_oe, 8'h0E);
		pk("slew", slew, 8'h5A);
		pk("threshold", schm, 8'h0C);
		pk("periph in", per_in, 8'h2C);
		@(posedge i_mclk);
		bus(1'b0, iop_pkg::OFS_PIN_LEVEL, 32'h0);
		chk("analog level", rd, 32'h0000_002C);
		// open drain on pins 0 and 1
		aout <= 8'h00;
		bus(1'b1, iop_pkg::OFS_OPEN_DRAIN, 32'h0000_0003);
		settle();
		pk("oe open drain", pin_oe, 8'h0E);
		pk("od data", pin_out & 8'h03, 8'h00);
		@(posedge i_mclk);
		// peripheral takes pin 3 and drives it low
		p_oe <= 8'h08;
		bus(1'b1, iop_pkg::OFS_PERIPH_SEL, 32'h0000_0008);
		settle();
		pk("periph data", pin_out & 8'h08, 8'h00);
		@(posedge i_mclk);
		bus(1'b0, iop_pkg::OFS_PIN_LEVEL, 32'h0);
		chk("periph level", rd, 32'h0000_0024);
		p_oe <= 8'h00;
		settle();
		pk("periph oe off", pin_oe, 8'h06);
		@(posedge i_mclk);
		// second reset in mid-run
		i_rst <= 1'b1;
		@(posedge i_mclk);
		i_rst <= 1'b0;
		@(posedge i_mclk);
		bus(1'b0, iop_pkg::OFS_OUT_LATCH, 32'h0);
		chk("latch after reset", rd, 32'h0);
		bus(1'b0, iop_pkg::OFS_PERIPH_SEL, 32'h0);
		chk("owner after reset", rd, 32'h0);
		settle();
		pk("oe after reset", pin_oe, 8'h00);
		give_verdict();
	end
endmodule // io_port_pin_control_test
